/* common/lane_swap_pkg.sv */
/*
 * Constants for the decoder endian lane swapper: register map, field positions,
 * reset values and lane geometry.
 * Assumes a single 50 MHz clock domain and a plain strobe register port.
 */
package lane_swap_pkg;

   // ==========================================================
   // data path geometry
   localparam int DATA_W = 64;
   localparam int WORD_W = 32;
   localparam int HALF_W = 16;
   localparam int BYTE_W = 8;
   localparam int HARD_PER_WORD = 32;
   localparam int INDEX_SIG_W = 15;
   localparam int EXTR_SIG_W = 7;

   // ==========================================================
   // register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] SWAP_CTRL_OFFSET = 8'h00;
   localparam logic [ADDR_W-1:0] SWAP_STATUS_OFFSET = 8'h04;
   localparam int INDEX_FMT_BIT = 0;
   localparam int EXTR_FMT_BIT = 1;
   localparam logic [1:0] SWAP_CTRL_RESET = 2'h0;
   // status: bit 0 system little-endian, bit 1 hard bit-order setting
   localparam int STAT_LITTLE_BIT = 0;
   localparam int STAT_ORDER_BIT = 1;

   // ==========================================================
   // kind of data on the path
   typedef enum logic [1:0] {
      KIND_HARD,
      KIND_INDEX,
      KIND_EXTR,
      KIND_NONE
   } data_kind_e;

endpackage

/* src/decoder_endian_lane_swapper.sv */
/*
 * Endianness manager between the decoder kernel data ports and a DMA
 * controller moving whole 32-bit words over a 64-bit path.
 * Hard decisions go kernel to DMA; indexes go DMA to kernel; extrinsics go
 * kernel to DMA. Each path has one register stage and a valid flag.
 * Assumes the system endian and hard bit-order settings are pins from outside
 * the clock domain, so they are synchronised.
 */
// Behaviour
// - hard decisions packed 32 per word, first word at base, next four bytes up
// - bit order zero: decision 0 in bit 0 through decision 31 in bit 31
// - bit order one: reverse decision placement inside each 32-bit word
// - indexes are 16-bit fields with 15 significant bits right-justified
// - extrinsics are 8-bit fields with 7 significant bits right-justified
// - index format one: indexes stored as native halfwords, two bytes apart
// - index format zero: indexes packed in 32-bit words, halfwords reordered
// - big-endian, index format zero: halfword lanes 1,0,3,2 become 3,2,1,0
// - big-endian, index format one: halfword lanes fully reversed
// - little-endian: index and extrinsic data pass unchanged
// - big-endian: exchange the two hard-decision words of each transfer
// - control bit 0 index format, bit 1 extrinsic format, rest reserved
// - big-endian, extrinsic format zero: bytes 3,2,1,0,7,6,5,4 become 7..0
// - big-endian, extrinsic format one: eight byte lanes fully reversed
module decoder_endian_lane_swapper (
   input wire logic sys_clk,
   input wire logic arst_n,
   // register port
   input wire logic [lane_swap_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // settings from outside the domain
   input wire logic system_little_endian,
   input wire logic hard_bit_order,
   // hard decisions: kernel to DMA
   input wire logic [lane_swap_pkg::DATA_W-1:0] hard_in,
   input wire logic hard_in_valid,
   output logic [lane_swap_pkg::DATA_W-1:0] hard_out,
   output logic hard_out_valid,
   // interleaver indexes: DMA to kernel
   input wire logic [lane_swap_pkg::DATA_W-1:0] index_in,
   input wire logic index_in_valid,
   output logic [lane_swap_pkg::DATA_W-1:0] index_out,
   output logic index_out_valid,
   // extrinsics: kernel to DMA
   input wire logic [lane_swap_pkg::DATA_W-1:0] extr_in,
   input wire logic extr_in_valid,
   output logic [lane_swap_pkg::DATA_W-1:0] extr_out,
   output logic extr_out_valid
);
   import lane_swap_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic [2:0] little_sync;
      logic [2:0] order_sync;
      logic little;
      logic order;
      logic [1:0] ctrl;
      logic [31:0] rdata;
      logic [DATA_W-1:0] hard;
      logic hard_v;
      logic [DATA_W-1:0] index;
      logic index_v;
      logic [DATA_W-1:0] extr;
      logic extr_v;
   } state_s;

   state_s st_q;
   state_s st_d;

   // ==========================================================
   // lane functions
   function automatic logic [WORD_W-1:0] rev_bits(input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] r;
      r = '0;
      for (int i = 0; i < WORD_W; i++) begin
         r[i] = w[WORD_W-1-i];
      end
      return r;
   endfunction

   function automatic logic [DATA_W-1:0] hard_map(input logic [DATA_W-1:0] d,
                                                 input logic little,
                                                 input logic order);
      logic [WORD_W-1:0] first;
      logic [WORD_W-1:0] second;
      first = d[WORD_W-1:0];
      second = d[DATA_W-1:WORD_W];
      // decision 0 sits in bit 0 as the kernel packs it
      if (order) begin
         first = rev_bits(first);
         second = rev_bits(second);
      end
      // first word at base, second word four bytes above
      if (little) begin
         return {second, first};
      end else begin
         return {first, second};
      end
   endfunction

   function automatic logic [DATA_W-1:0] index_map(input logic [DATA_W-1:0] d,
                                                  input logic little,
                                                  input logic native);
      logic [HALF_W-1:0] h [4];
      for (int i = 0; i < 4; i++) begin
         h[i] = d[i*HALF_W +: HALF_W];
      end
      if (little) begin
         return d;
      end else if (native) begin
         // lanes 0,1,2,3 from the top become kernel lanes 3,2,1,0
         return {h[0], h[1], h[2], h[3]};
      end else begin
         // lanes 1,0,3,2 from the top become kernel lanes 3,2,1,0
         return {h[1], h[0], h[3], h[2]};
      end
   endfunction

   function automatic logic [DATA_W-1:0] extr_map(input logic [DATA_W-1:0] d,
                                                 input logic little,
                                                 input logic native);
      logic [DATA_W-1:0] r;
      r = d;
      if (!little) begin
         for (int i = 0; i < 8; i++) begin
            if (native) begin
               r[i*BYTE_W +: BYTE_W] = d[(7-i)*BYTE_W +: BYTE_W];
            end else begin
               r[i*BYTE_W +: BYTE_W] = d[(i^4)*BYTE_W +: BYTE_W];
            end
         end
      end
      return r;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      st_d = st_q;
      // three-stage synchronisers; change taken when stages two and three agree
      st_d.little_sync = {st_q.little_sync[1:0], system_little_endian};
      st_d.order_sync = {st_q.order_sync[1:0], hard_bit_order};
      if (st_q.little_sync[2] == st_q.little_sync[1]) begin
         st_d.little = st_q.little_sync[2];
      end
      if (st_q.order_sync[2] == st_q.order_sync[1]) begin
         st_d.order = st_q.order_sync[2];
      end

      // register port
      if (reg_write && reg_addr == SWAP_CTRL_OFFSET) begin
         st_d.ctrl = reg_wdata[1:0];
      end
      st_d.rdata = '0;
      if (reg_read) begin
         unique case (reg_addr)
            SWAP_CTRL_OFFSET: st_d.rdata = {30'h0, st_q.ctrl};
            SWAP_STATUS_OFFSET: st_d.rdata = {30'h0, st_q.order, st_q.little};
            default: st_d.rdata = '0;
         endcase
      end

      // data paths, one stage each; indexes carry 15 significant bits per lane
      st_d.hard_v = hard_in_valid;
      if (hard_in_valid) begin
         st_d.hard = hard_map(hard_in, st_q.little, st_q.order);
      end
      st_d.index_v = index_in_valid;
      if (index_in_valid) begin
         st_d.index = index_map(index_in, st_q.little, st_q.ctrl[INDEX_FMT_BIT]);
      end
      st_d.extr_v = extr_in_valid;
      if (extr_in_valid) begin
         st_d.extr = extr_map(extr_in, st_q.little, st_q.ctrl[EXTR_FMT_BIT]);
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
         st_q.ctrl <= SWAP_CTRL_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign hard_out = st_q.hard;
   assign hard_out_valid = st_q.hard_v;
   assign index_out = st_q.index;
   assign index_out_valid = st_q.index_v;
   assign extr_out = st_q.extr;
   assign extr_out_valid = st_q.extr_v;

endmodule

/* testbench/lane_swap_chk.sv */
/* port assertions for the lane swapper.
   assumes binding to every port of decoder_endian_lane_swapper. */
module lane_swap_chk (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic system_little_endian,
   input wire logic hard_bit_order,
   input wire logic [63:0] hard_in,
   input wire logic hard_in_valid,
   input wire logic [63:0] hard_out,
   input wire logic hard_out_valid,
   input wire logic [63:0] index_in,
   input wire logic index_in_valid,
   input wire logic [63:0] index_out,
   input wire logic index_out_valid,
   input wire logic [63:0] extr_in,
   input wire logic extr_in_valid,
   input wire logic [63:0] extr_out,
   input wire logic extr_out_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================
   // settings held long enough to pass the synchroniser
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence lit; system_little_endian [*6]; endsequence
   sequence bigz; (!system_little_endian && !hard_bit_order) [*6]; endsequence
   chk_hard_beat: assert property (hard_in_valid |=> hard_out_valid)
      else $error("hard beat lost");
   chk_index_beat: assert property (index_in_valid |=> index_out_valid)
      else $error("index beat lost");
   chk_extr_beat: assert property (extr_in_valid |=> extr_out_valid)
      else $error("extrinsic beat lost");
   chk_index_pass: assert property (lit ##0 index_in_valid |=> index_out == $past(index_in))
      else $error("index altered in little mode");
   chk_extr_pass: assert property (lit ##0 extr_in_valid |=> extr_out == $past(extr_in))
      else $error("extrinsic altered in little mode");
   chk_hard_swap: assert property (bigz ##0 hard_in_valid |=>
      hard_out == {$past(hard_in[31:0]), $past(hard_in[63:32])}) else $error("hard words not swapped");
   chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   chk_ctrl_back: assert property ((reg_write && reg_addr == 8'h00) ##1
      (reg_read && reg_addr == 8'h00) |=> reg_rdata == {30'h0, $past(reg_wdata[1:0], 2)})
      else $error("control readback wrong");
endmodule
bind decoder_endian_lane_swapper lane_swap_chk chk (.*);

/* testbench/dma_model.sv */
/* dma side: hands index beats to the swapper as whole 64-bit words.
   assumes the bench raises go for one cycle per beat, after a clock edge. */
module dma_model (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [63:0] beat,
   output logic [63:0] index_in,
   output logic index_in_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================
   // idle lines invert every cycle, alternating between the last word and its inverse
   initial index_in_valid = 1'b0;
   initial index_in = 64'h0;
   always @(posedge sys_clk) begin
      index_in_valid <= go;
      index_in <= go ? beat : ~index_in;
   end
endmodule

/* testbench/decoder_endian_lane_swapper_bench.sv */
/* self-checking bench for the lane swapper.
   assumes dma_model and the bound checker are compiled beside it. */
module decoder_endian_lane_swapper_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, arst_n = 0, reg_write = 0, reg_read = 0, go = 0, index_in_valid;
   logic system_little_endian = 0, hard_bit_order = 0, hard_in_valid = 0, extr_in_valid = 0;
   logic [7:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata;
   logic [63:0] hard_in = 0, extr_in = 0, beat = 0, index_in, hard_out, index_out, extr_out;
   logic hard_out_valid, index_out_valid, extr_out_valid;
   int num_errors = 0, check_count = 0;
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
   decoder_endian_lane_swapper uut (.*);
   dma_model dma (.*);
   // ======================================
   // clock, watchdog, tasks
   initial forever #10 sys_clk = ~sys_clk;
   initial begin
      #100us;
      num_errors++;
      report_and_stop;
   end
   task report_and_stop;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // write strobe is lowered by the read that always follows it
   task reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
   endtask
   task reg_rd(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge sys_clk);
      reg_write <= 1'b0;
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 `CHK(n, e, reg_rdata)
   endtask
   task t_regs;
      reg_rd(8'h00, 32'h0, "ctrl reset");
      reg_wr(8'h00, 32'hffffffff);
      reg_rd(8'h00, 32'h3, "ctrl reserved");
      reg_wr(8'h04, 32'hffffffff);
      reg_rd(8'h08, 32'h0, "unmapped");
      reg_rd(8'h04, 32'h0, "status");
   endtask
   task t_path(input logic le, input logic ord, input logic [1:0] fmt);
      logic [31:0] r0, r1;
      logic [63:0] h, ri, rx;
      reg_wr(8'h00, {30'h0, fmt});
      system_little_endian <= le;
      hard_bit_order <= ord;
      reg_rd(8'h00, {30'h0, fmt}, "ctrl");
      repeat (5) @(posedge sys_clk);
      go <= 1'b1;
      beat <= 64'h0123456789abcdef;
      @(posedge sys_clk);
      go <= 1'b0;
      hard_in <= 64'h80000001f0000003;
      extr_in <= 64'h0011223344556677;
      hard_in_valid <= 1'b1;
      extr_in_valid <= 1'b1;
      @(posedge sys_clk);
      hard_in_valid <= 1'b0;
      extr_in_valid <= 1'b0;
      #1;
      r0 = {<<{hard_in[31:0]}};
      r1 = {<<{hard_in[63:32]}};
      ri = {<<16{beat}};
      rx = {<<8{extr_in}};
      h = ord ? {r1, r0} : hard_in;
      `CHK("valids", 3'b111, {hard_out_valid, index_out_valid, extr_out_valid})
      `CHK("hard", le ? h : {h[31:0], h[63:32]}, hard_out)
      `CHK("index", le ? beat : (fmt[0] ? ri : {beat[31:0], beat[63:32]}), index_out)
      `CHK("extr", le ? extr_in : (fmt[1] ? rx : {extr_in[31:0], extr_in[63:32]}), extr_out)
      reg_rd(8'h04, {30'h0, ord, le}, "status");
   endtask
   // mid-run reset: control and outputs fall back to zero
   task t_reset;
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      `CHK("valids reset", 3'b000, {hard_out_valid, index_out_valid, extr_out_valid})
      `CHK("hard reset", 64'h0, hard_out)
      reg_rd(8'h00, 32'h0, "ctrl after reset");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_regs;
      t_reset;
      for (int i = 0; i < 16; i++) begin
         t_path(i[3], i[2], i[1:0]);
      end
      report_and_stop;
   end
endmodule
